/* File: vram_host_pkg.sv */
// vram_host_pkg: constants, register map, commands and states of the
// host-side video DRAM write controller.
// assumes: a 10 MHz controller clock.
package vram_host_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int POWERUP_WAIT_US = 100;
    // least time: round up to whole cycles
    localparam int WAIT_CYC =
        (POWERUP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_W = 11;
    localparam logic [WAIT_W-1:0] WAIT_LOAD = WAIT_W'(WAIT_CYC);
    localparam int INIT_CYCLES = 8;
    localparam int INIT_W = 4;
    localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYCLES);

    localparam int ADDR_W = 9;
    localparam int DQ_W = 8;
    localparam int RA_W = 3;
    localparam int RD_W = 16;
    localparam int OP_W = 4;

    localparam logic [RA_W-1:0] REG_CTRL = 3'h0;
    localparam logic [RA_W-1:0] REG_ROW = 3'h1;
    localparam logic [RA_W-1:0] REG_COL = 3'h2;
    localparam logic [RA_W-1:0] REG_WDATA = 3'h3;
    localparam logic [RA_W-1:0] REG_WMASK = 3'h4;
    localparam logic [RA_W-1:0] REG_MODE = 3'h5;
    localparam logic [RA_W-1:0] REG_STATUS = 3'h6;
    localparam logic [RA_W-1:0] REG_RDATA = 3'h7;

    localparam int MODE_PERSIST = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_INIT = 1;
    localparam int STAT_REFUSED = 2;
    localparam int STAT_SPLIT = 3;

    // select level at the row strobe of a register-reset refresh
    localparam logic RESET_REFRESH_SEL = 1'b1;

    typedef enum logic [OP_W-1:0] {
        OP_PLAIN = 4'h0,
        OP_MASKED = 4'h1,
        OP_BLOCK = 4'h2,
        OP_MBLOCK = 4'h3,
        OP_LMASK = 4'h4,
        OP_LCOLOR = 4'h5,
        OP_READ = 4'h6,
        OP_RMW = 4'h7,
        OP_RREFRESH = 4'h8,
        OP_SHIFT_CLK = 4'h9,
        OP_INIT = 4'hA
    } op_t;

    typedef enum logic [14:0] {
        ST_IDLE = 15'h0001,
        ST_INIT_WAIT = 15'h0002,
        ST_ROW_SET = 15'h0004,
        ST_RAS_LOW = 15'h0008,
        ST_COL_SET = 15'h0010,
        ST_CAS_LOW = 15'h0020,
        ST_RD_OE = 15'h0040,
        ST_WR_SET = 15'h0080,
        ST_WR_WE = 15'h0100,
        ST_CBR_SET = 15'h0200,
        ST_CBR_CAS = 15'h0400,
        ST_HOLD = 15'h0800,
        ST_PRE = 15'h1000,
        ST_SHIFT_HI = 15'h2000,
        ST_SHIFT_LO = 15'h4000
    } state_t;
endpackage : vram_host_pkg

/* File: wait_timer_if.sv */
// wait_timer_if: reload and expiry between the controller and its timer.
// assumes: both ends on the controller clock.
`timescale 1ns/100ps
interface wait_timer_if;
    logic load;
    logic done;
    modport owner (output load, input done);
    modport timer (input load, output done);
endinterface : wait_timer_if

/* File: vram_wait_timer.sv */
// vram_wait_timer: power-up wait counter, armed out of reset.
// assumes: load is a one-cycle pulse from the controller.
`timescale 1ns/100ps
module vram_wait_timer
    import vram_host_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    wait_timer_if.timer tmr
);
    logic [WAIT_W-1:0] cnt_reg;
    logic [WAIT_W-1:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (tmr.load) begin
            cnt_next = WAIT_LOAD;
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - WAIT_W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_reg <= WAIT_LOAD;
        end else if (i_ce) begin
            cnt_reg <= cnt_next;
        end
    end

    assign tmr.done = (cnt_reg == '0) && !tmr.load;
endmodule : vram_wait_timer

/* File: vram_write_host.sv */
// vram_write_host: host controller driving the random-access port of a
// clockless video DRAM: write modes, register loads, reads, refresh.
// assumes: software port with one-cycle strobes; board resolves the
// shared data lines from o_io_out/o_io_oe_n and the DRAM's own drive.
// Contract
// - select low at both strobes, write enable high at row: plain write
// - select low at row, high at column, enable high: block write
// - select high at row loads mask (column low) or colour (column high)
// - after power-up wait 100 us, then eight reset refresh cycles
// - give one serial clock pulse before trusting the split-half flag
// - hold the spare function pin low in every operation
// - turn the device's output buffer off before driving write data
`timescale 1ns/100ps
module vram_write_host
    import vram_host_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic [RA_W-1:0] i_addr,
    input wire logic [RD_W-1:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [RD_W-1:0] o_rd_data,
    output logic o_ras_n,
    output logic o_cas_n,
    output logic o_we_n,
    output logic o_oe_n,
    output logic [ADDR_W-1:0] o_addr,
    output logic o_special_function_select,
    output logic o_spare_function_pin,
    output logic o_serial_shift_clock,
    output logic [DQ_W-1:0] o_io_out,
    output logic o_io_oe_n,
    input wire logic [DQ_W-1:0] i_io_in,
    input wire logic i_split_half_flag
);
    state_t state_reg, state_next;
    op_t op_reg, op_next;
    op_t cmd_op;
    logic [INIT_W-1:0] init_cnt_reg, init_cnt_next;
    logic init_done_reg, init_done_next;
    logic shifted_reg, shifted_next;
    logic [DQ_W-1:0] cap_reg, cap_next;
    logic [ADDR_W-1:0] row_reg, row_next, col_reg, col_next;
    logic [DQ_W-1:0] wdata_reg, wdata_next, wmask_reg, wmask_next;
    logic persist_reg, persist_next;
    logic refused_reg, refused_next;
    logic [RD_W-1:0] rd_data_next;
    logic ras_n_next, cas_n_next, we_n_next, oe_n_next;
    logic dsf_next, shift_next, io_oe_n_next;
    logic [ADDR_W-1:0] addr_next;
    logic [DQ_W-1:0] io_out_next;
    logic ctrl_wr, go, tmr_load, release_pins;
    logic cmd_masked, cmd_rowsel, op_colsel, op_rd;

    wait_timer_if tmr_if();

    vram_wait_timer u_timer (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .tmr(tmr_if.timer)
    );
    assign tmr_if.load = tmr_load;

    assign cmd_op = op_t'(i_wr_data[OP_W-1:0]);
    assign ctrl_wr = i_wr && (i_addr == REG_CTRL);
    assign go = ctrl_wr && (state_reg == ST_IDLE) && (cmd_op <= OP_INIT);
    assign cmd_masked = (cmd_op == OP_MASKED) || (cmd_op == OP_MBLOCK);
    assign cmd_rowsel = (cmd_op == OP_LMASK) || (cmd_op == OP_LCOLOR);
    assign op_colsel = (op_reg == OP_BLOCK) || (op_reg == OP_MBLOCK)
        || (op_reg == OP_LCOLOR);
    assign op_rd = (op_reg == OP_READ) || (op_reg == OP_RMW);

    // software registers
    always_comb begin
        row_next = row_reg;
        col_next = col_reg;
        wdata_next = wdata_reg;
        wmask_next = wmask_reg;
        persist_next = persist_reg;
        refused_next = refused_reg;
        rd_data_next = '0;
        if (i_wr) begin
            case (i_addr)
                REG_ROW: row_next = i_wr_data[ADDR_W-1:0];
                REG_COL: col_next = i_wr_data[ADDR_W-1:0];
                REG_WDATA: wdata_next = i_wr_data[DQ_W-1:0];
                REG_WMASK: wmask_next = i_wr_data[DQ_W-1:0];
                REG_MODE: persist_next = i_wr_data[MODE_PERSIST];
                REG_STATUS: begin
                    if (i_wr_data[STAT_REFUSED]) begin
                        refused_next = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // set wins over a clear in the same cycle
        if (ctrl_wr && !go) begin
            refused_next = 1'b1;
        end
        if (i_rd) begin
            case (i_addr)
                REG_CTRL: rd_data_next = RD_W'(op_reg);
                REG_ROW: rd_data_next = RD_W'(row_reg);
                REG_COL: rd_data_next = RD_W'(col_reg);
                REG_WDATA: rd_data_next = RD_W'(wdata_reg);
                REG_WMASK: rd_data_next = RD_W'(wmask_reg);
                REG_MODE: rd_data_next[MODE_PERSIST] = persist_reg;
                REG_STATUS: begin
                    rd_data_next[STAT_BUSY] = (state_reg != ST_IDLE);
                    rd_data_next[STAT_INIT] = init_done_reg;
                    rd_data_next[STAT_REFUSED] = refused_reg;
                    // flag may float until a shift clock has been given
                    rd_data_next[STAT_SPLIT] = shifted_reg
                        && i_split_half_flag;
                end
                default: rd_data_next = RD_W'(cap_reg);
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            row_reg <= '0;
            col_reg <= '0;
            wdata_reg <= '0;
            wmask_reg <= '0;
            persist_reg <= 1'b0;
            refused_reg <= 1'b0;
            o_rd_data <= '0;
        end else if (i_ce) begin
            row_reg <= row_next;
            col_reg <= col_next;
            wdata_reg <= wdata_next;
            wmask_reg <= wmask_next;
            persist_reg <= persist_next;
            refused_reg <= refused_next;
            o_rd_data <= rd_data_next;
        end
    end

    // sequencer and pins; every pin changes at least one state ahead of its strobe (refresh select: two states before the row strobe)
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        init_cnt_next = init_cnt_reg;
        init_done_next = init_done_reg;
        shifted_next = shifted_reg;
        cap_next = cap_reg;
        ras_n_next = o_ras_n;
        cas_n_next = o_cas_n;
        we_n_next = o_we_n;
        oe_n_next = o_oe_n;
        addr_next = o_addr;
        dsf_next = o_special_function_select;
        shift_next = o_serial_shift_clock;
        io_out_next = o_io_out;
        io_oe_n_next = o_io_oe_n;
        tmr_load = 1'b0;
        release_pins = 1'b0;
        case (state_reg)
            ST_INIT_WAIT: begin
                if (tmr_if.done) begin
                    state_next = ST_CBR_SET;
                    dsf_next = RESET_REFRESH_SEL;
                end
            end
            ST_IDLE: begin
                if (go) begin
                    op_next = cmd_op;
                    case (cmd_op)
                        OP_RREFRESH: begin
                            state_next = ST_CBR_SET;
                            dsf_next = RESET_REFRESH_SEL;
                        end
                        OP_SHIFT_CLK: begin
                            state_next = ST_SHIFT_HI;
                            shift_next = 1'b1;
                        end
                        OP_INIT: begin
                            state_next = ST_INIT_WAIT;
                            tmr_load = 1'b1;
                            init_done_next = 1'b0;
                            init_cnt_next = '0;
                        end
                        default: begin
                            state_next = ST_ROW_SET;
                            addr_next = row_reg;
                            dsf_next = cmd_rowsel;
                            we_n_next = !cmd_masked;
                            io_out_next = wmask_reg;
                            // stored-mask mode leaves the row lines undriven
                            io_oe_n_next = !(cmd_masked && !persist_reg);
                        end
                    endcase
                end
            end
            ST_ROW_SET: begin
                state_next = ST_RAS_LOW;
                ras_n_next = 1'b0;
            end
            ST_RAS_LOW: begin
                state_next = ST_COL_SET;
                addr_next = col_reg;
                dsf_next = op_colsel;
                io_out_next = wdata_reg;
                // early write: enable low before the column strobe
                we_n_next = op_rd;
                io_oe_n_next = op_rd;
            end
            ST_COL_SET: begin
                state_next = ST_CAS_LOW;
                cas_n_next = 1'b0;
            end
            ST_CAS_LOW: begin
                if (op_rd) begin
                    state_next = ST_RD_OE;
                    oe_n_next = 1'b0;
                end else begin
                    state_next = ST_PRE;
                    release_pins = 1'b1;
                end
            end
            ST_RD_OE: begin
                cap_next = i_io_in;
                oe_n_next = 1'b1;
                if (op_reg == OP_RMW) begin
                    state_next = ST_WR_SET;
                end else begin
                    state_next = ST_PRE;
                    release_pins = 1'b1;
                end
            end
            ST_WR_SET: begin
                state_next = ST_WR_WE;
                io_out_next = wdata_reg;
                io_oe_n_next = 1'b0;
            end
            ST_WR_WE: begin
                state_next = ST_HOLD;
                we_n_next = 1'b0;
            end
            ST_CBR_SET: begin
                state_next = ST_CBR_CAS;
                cas_n_next = 1'b0;
            end
            ST_CBR_CAS: begin
                state_next = ST_HOLD;
                ras_n_next = 1'b0;
            end
            ST_HOLD: begin
                state_next = ST_PRE;
                release_pins = 1'b1;
                if (!init_done_reg) begin
                    init_cnt_next = init_cnt_reg + INIT_W'(1);
                end
            end
            ST_PRE: begin
                if (init_done_reg) begin
                    state_next = ST_IDLE;
                end else if (init_cnt_reg == INIT_LAST) begin
                    state_next = ST_SHIFT_HI;
                    shift_next = 1'b1;
                end else begin
                    state_next = ST_CBR_SET;
                    dsf_next = RESET_REFRESH_SEL;
                end
            end
            ST_SHIFT_HI: begin
                state_next = ST_SHIFT_LO;
                shift_next = 1'b0;
            end
            ST_SHIFT_LO: begin
                state_next = ST_IDLE;
                shifted_next = 1'b1;
                init_done_next = 1'b1;
            end
            default: begin
                state_next = ST_IDLE;
                release_pins = 1'b1;
            end
        endcase
        if (release_pins) begin
            ras_n_next = 1'b1;
            cas_n_next = 1'b1;
            we_n_next = 1'b1;
            oe_n_next = 1'b1;
            io_oe_n_next = 1'b1;
            dsf_next = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= ST_INIT_WAIT;
            op_reg <= OP_PLAIN;
            init_cnt_reg <= '0;
            init_done_reg <= 1'b0;
            shifted_reg <= 1'b0;
            cap_reg <= '0;
            o_ras_n <= 1'b1;
            o_cas_n <= 1'b1;
            o_we_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_addr <= '0;
            o_special_function_select <= 1'b0;
            o_spare_function_pin <= 1'b0;
            o_serial_shift_clock <= 1'b0;
            o_io_out <= '0;
            o_io_oe_n <= 1'b1;
        end else if (i_ce) begin
            state_reg <= state_next;
            op_reg <= op_next;
            init_cnt_reg <= init_cnt_next;
            init_done_reg <= init_done_next;
            shifted_reg <= shifted_next;
            cap_reg <= cap_next;
            o_ras_n <= ras_n_next;
            o_cas_n <= cas_n_next;
            o_we_n <= we_n_next;
            o_oe_n <= oe_n_next;
            o_addr <= addr_next;
            o_special_function_select <= dsf_next;
            o_spare_function_pin <= 1'b0;
            o_serial_shift_clock <= shift_next;
            o_io_out <= io_out_next;
            o_io_oe_n <= io_oe_n_next;
        end
    end

    // checks; sampled only on enabled edges
    logic [WAIT_W-1:0] wait_cnt_reg;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wait_cnt_reg <= '0;
        end else if (i_ce) begin
            if (tmr_load) begin
                wait_cnt_reg <= '0;
            end else if (state_reg == ST_INIT_WAIT) begin
                wait_cnt_reg <= wait_cnt_reg + WAIT_W'(1);
            end
        end
    end

    default clocking chk_cb @(posedge i_clk iff i_ce);
    endclocking
    default disable iff (!i_resetn);

    sequence ras_sel(logic d, logic w);
        $fell(o_ras_n) && (o_special_function_select == d) && (o_we_n == w);
    endsequence

    sequence cas_sel(logic d);
        $fell(o_cas_n) && (o_special_function_select == d) && !o_io_oe_n;
    endsequence

    plain_write_a: assert property (
        // power-up refreshes run with op_reg still at its reset code
        (op_reg == OP_PLAIN) && $fell(o_ras_n) && o_cas_n
        |-> ras_sel(1'b0, 1'b1) ##2 cas_sel(1'b0))
        else $error("plain write strobe levels wrong");

    block_write_a: assert property (
        (op_reg == OP_BLOCK) && $fell(o_ras_n)
        |-> ras_sel(1'b0, 1'b1) ##2 cas_sel(1'b1))
        else $error("block write strobe levels wrong");

    mask_load_a: assert property (
        (op_reg == OP_LMASK) && $fell(o_ras_n)
        |-> ras_sel(1'b1, 1'b1) ##2 cas_sel(1'b0))
        else $error("mask load strobe levels wrong");

    powerup_wait_a: assert property (
        $fell(o_cas_n) && !init_done_reg |-> wait_cnt_reg >= WAIT_LOAD)
        else $error("refresh started before power-up wait");

    init_count_a: assert property (
        $rose(init_done_reg) |-> init_cnt_reg == INIT_LAST)
        else $error("wrong number of init cycles");

    shift_first_a: assert property (
        $rose(init_done_reg) |-> shifted_reg && !o_serial_shift_clock)
        else $error("init ended without a shift clock");

    spare_low_a: assert property (
        !o_spare_function_pin)
        else $error("spare pin not held low");

    buffer_off_a: assert property (
        $fell(o_io_oe_n) |-> o_oe_n && $past(o_oe_n))
        else $error("data driven while device output on");
endmodule : vram_write_host

/* File: vram_dev_model.sv */
// vram_dev_model: behavioural random-access port of the video DRAM.
// assumes: host strobes on its pins; bench resolves the data lines.
`timescale 1ns/100ps
module vram_dev_model
    import vram_host_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_sel,
    input wire logic i_spare,
    input wire logic i_shift_clk,
    input wire logic [DQ_W-1:0] i_io,
    input wire logic i_host_oe_n,
    input wire logic i_persist,
    output logic [DQ_W-1:0] o_io,
    output logic o_drive,
    output logic o_flag
);
    logic [DQ_W-1:0] mem [16];
    logic [DQ_W-1:0] mask_reg = 8'h00;
    logic [DQ_W-1:0] colour_reg = 8'h00;
    logic [DQ_W-1:0] row_mask, msk;
    logic sel_row, we_row;
    logic cbr = 1'b0;
    logic rd_cyc = 1'b0;
    logic shifted = 1'b0;
    logic pat = 1'b0;
    logic [3:0] col;
    int n_init = 0;
    int num_viol = 0;
    realtime t_up = 0;

    initial foreach (mem[i]) mem[i] = 8'h00;

    task automatic put(input int a, input logic [DQ_W-1:0] d);
        mem[a] = (d & msk) | (mem[a] & ~msk);
    endtask : put

    always @(posedge i_resetn) t_up = $realtime;
    always @(negedge i_ras_n) begin
        if ($realtime - t_up < 100000.0) num_viol++;
        if (cbr) n_init++;
        else if (n_init < 8) num_viol++;
        sel_row = i_sel;
        we_row = i_we_n;
        row_mask = i_io;
    end
    always @(posedge i_ras_n) begin
        cbr = 1'b0;
        rd_cyc = 1'b0;
    end
    always @(negedge i_cas_n) begin
        col = i_addr[3:0];
        if (i_ras_n) cbr = 1'b1;
        else if (sel_row) begin
            if (i_sel) colour_reg = i_io;
            else mask_reg = i_io;
        end else begin
            msk = we_row ? 8'hFF : i_persist ? mask_reg : row_mask;
            if (i_sel) begin
                for (int i = 0; i < 8; i++)
                    if (i_io[i]) put(i_addr[3] * 8 + i, colour_reg);
            end else if (!i_we_n) put(col, i_io);
            else rd_cyc = 1'b1;
        end
    end
    // late write enable: the old data went out first
    always @(negedge i_we_n)
        if (!i_ras_n && !i_cas_n && rd_cyc) put(col, i_io);
    assign o_drive = !i_ras_n && !i_cas_n && !i_oe_n && rd_cyc;
    assign o_io = mem[col];
    always @(posedge i_clk) begin
        pat <= ~pat;
        if (i_resetn && (i_spare || (o_drive && !i_host_oe_n)))
            num_viol++;
    end
    always @(posedge i_shift_clk) shifted = 1'b1;
    // floats until the first shift clock
    assign o_flag = shifted ? 1'b1 : pat;
endmodule : vram_dev_model

/* File: testbench.sv */
// testbench: drives the write controller over its register port and
// judges the device model's state and the read-back data.
`timescale 1ns/100ps
module testbench
    import vram_host_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic persist = 1'b0;
    logic [RA_W-1:0] addr = 3'h0;
    logic [RD_W-1:0] wdata = 16'h0000;
    logic [RD_W-1:0] rd_data;
    logic ras_n, cas_n, we_n, oe_n, sel, spare, shift_clk, io_oe_n;
    logic dev_drv, flag;
    logic [ADDR_W-1:0] d_addr;
    logic [DQ_W-1:0] io_out, dev_io, io_line;
    logic [DQ_W-1:0] last_io = 8'h00;
    int num_errors = 0;
    int samples_checked = 0;

    always #50 clk = ~clk;
    // undriven lines: inverse of the last level, never a stable guess
    always_comb begin
        if (!io_oe_n) io_line = io_out;
        else if (dev_drv) io_line = dev_io;
        else io_line = ~last_io;
    end
    always @(posedge clk) last_io <= io_line;

    vram_write_host dut (.i_clk(clk), .i_resetn(resetn), .i_ce(ce),
        .i_addr(addr), .i_wr_data(wdata), .i_wr(wr), .i_rd(rd),
        .o_rd_data(rd_data), .o_ras_n(ras_n), .o_cas_n(cas_n),
        .o_we_n(we_n), .o_oe_n(oe_n), .o_addr(d_addr),
        .o_special_function_select(sel), .o_spare_function_pin(spare),
        .o_serial_shift_clock(shift_clk), .o_io_out(io_out),
        .o_io_oe_n(io_oe_n), .i_io_in(io_line), .i_split_half_flag(flag));
    vram_dev_model dev (.i_clk(clk), .i_resetn(resetn), .i_ras_n(ras_n),
        .i_cas_n(cas_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_addr(d_addr),
        .i_sel(sel), .i_spare(spare), .i_shift_clk(shift_clk),
        .i_io(io_line),
        .i_host_oe_n(io_oe_n), .i_persist(persist), .o_io(dev_io),
        .o_drive(dev_drv), .o_flag(flag));

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus_wr(input logic [RA_W-1:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [RA_W-1:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rd_data;
    endtask : bus_rd

    task automatic run_op(input logic [3:0] op);
        logic [15:0] s;
        int n = 0;
        bus_wr(REG_CTRL, {12'h000, op});
        do begin
            bus_rd(REG_STATUS, s);
            n++;
        // a re-run of init keeps busy high for some 1050 cycles
        end while (s[STAT_BUSY] !== 1'b0 && n < 700);
        chk("busy", 16'h0000, {15'h0000, s[STAT_BUSY]});
    endtask : run_op

    task automatic mem_is(input int a, input logic [7:0] exp);
        chk("cell", {8'h00, exp}, {8'h00, dev.mem[a]});
    endtask : mem_is

    task automatic t_init();
        logic [15:0] s;
        int n = 0;
        bus_rd(REG_ROW, s);
        chk("row reset", 16'h0000, s);
        do begin
            bus_rd(REG_STATUS, s);
            n++;
        end while (s[STAT_INIT] !== 1'b1 && n < 1500);
        chk("split flag", 16'h0001, {15'h0000, s[STAT_SPLIT]});
        chk("init cycles", 16'h0001, {15'h0000, dev.n_init >= 8});
    endtask : t_init

    task automatic t_loads();
        bus_wr(REG_WDATA, 16'h00F0);
        run_op(OP_LMASK);
        chk("mask reg", 16'h00F0, {8'h00, dev.mask_reg});
        bus_wr(REG_WDATA, 16'h003C);
        run_op(OP_LCOLOR);
        chk("colour reg", 16'h003C, {8'h00, dev.colour_reg});
    endtask : t_loads

    task automatic t_plain();
        logic [15:0] s;
        bus_wr(REG_COL, 16'h0003);
        bus_wr(REG_WDATA, 16'h00A5);
        run_op(OP_PLAIN);
        mem_is(3, 8'hA5);
        run_op(OP_READ);
        bus_rd(REG_RDATA, s);
        chk("read back", 16'h00A5, s);
    endtask : t_plain

    task automatic t_masked();
        bus_wr(REG_WMASK, 16'h000F);
        bus_wr(REG_WDATA, 16'h005A);
        run_op(OP_MASKED);
        mem_is(3, 8'hAA);
        bus_wr(REG_MODE, 16'h0001);
        persist = 1'b1;
        bus_wr(REG_WDATA, 16'h0000);
        run_op(OP_MASKED);
        mem_is(3, 8'h0A);
        bus_wr(REG_MODE, 16'h0000);
        persist = 1'b0;
    endtask : t_masked

    task automatic t_block();
        bus_wr(REG_COL, 16'h0008);
        bus_wr(REG_WDATA, 16'h0081);
        run_op(OP_BLOCK);
        mem_is(8, 8'h3C);
        mem_is(15, 8'h3C);
        mem_is(9, 8'h00);
        bus_wr(REG_WDATA, 16'h0002);
        run_op(OP_MBLOCK);
        mem_is(9, 8'h0C);
        mem_is(8, 8'h3C);
    endtask : t_block

    task automatic t_rmw();
        logic [15:0] s;
        bus_wr(REG_COL, 16'h0003);
        bus_wr(REG_WDATA, 16'h0077);
        run_op(OP_RMW);
        bus_rd(REG_RDATA, s);
        chk("old data", 16'h000A, s);
        mem_is(3, 8'h77);
    endtask : t_rmw

    task automatic t_service();
        logic [15:0] s;
        int n0;
        n0 = dev.n_init;
        run_op(OP_RREFRESH);
        chk("refresh count", 16'h0001, 16'(dev.n_init - n0));
        run_op(OP_SHIFT_CLK);
        run_op(OP_INIT);
        chk("init rerun", 16'h0009, 16'(dev.n_init - n0));
        bus_rd(REG_STATUS, s);
        chk("init again", 16'h0001, {15'h0000, s[STAT_INIT]});
        chk("split again", 16'h0001, {15'h0000, s[STAT_SPLIT]});
    endtask : t_service

    task automatic t_refused();
        logic [15:0] s;
        bus_wr(REG_CTRL, 16'h000B);
        bus_rd(REG_STATUS, s);
        chk("refused", 16'h0001, {15'h0000, s[STAT_REFUSED]});
        bus_wr(REG_STATUS, 16'h0004);
        bus_rd(REG_STATUS, s);
        chk("refused clear", 16'h0000, {15'h0000, s[STAT_REFUSED]});
        chk("pin faults", 16'h0000, 16'(dev.num_viol));
    endtask : t_refused

    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test

    // whole run is some 2200 cycles
    initial begin
        #2000000;
        num_errors++;
        end_of_test();
    end

    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_init();
        t_loads();
        t_plain();
        t_masked();
        t_block();
        t_rmw();
        t_service();
        t_refused();
        end_of_test();
    end
endmodule : testbench
